// File: core/uchp_consts.svh
`ifndef UCHP_CONSTS_SVH
`define UCHP_CONSTS_SVH

// Bus widths of the parallel cell port
`define UCHP_DATA_W        8
`define UCHP_ADDR_W        3
// Port address that no strap setting answers to
`define UCHP_NULL_PORT     3'h7

// Controller register map, byte addresses on the software port
`define UCHP_REG_W         8
`define UCHP_REG_TX_DATA   8'h00
`define UCHP_REG_RX_DATA   8'h04
`define UCHP_REG_STATUS    8'h08
`define UCHP_REG_PORT      8'h0c
`define UCHP_REG_INT_STAT  8'h10
`define UCHP_REG_INT_CLR   8'h14
`define UCHP_REG_INT_EN    8'h18

// Interrupt status, clear and enable bit positions
`define UCHP_IRQ_W         3
`define UCHP_IRQ_TX_DONE   0
`define UCHP_IRQ_RX_READY  1
`define UCHP_IRQ_TX_DROP   2

// Status register bit positions
`define UCHP_ST_TX_BUSY    0
`define UCHP_ST_RX_VALID   1
`define UCHP_ST_CASCADE    2
`define UCHP_ST_TX_FULL    3
`define UCHP_ST_RX_EMPTY   4
`define UCHP_ST_TX_CLAV_B  5
`define UCHP_ST_RX_CLAV_B  6

// Reset values
`define UCHP_RST_PORT      3'h0
`define UCHP_RST_INT_EN    3'h0

`endif

// File: core/uchp_device_end.sv
// Overview of operation
// - Cascade strap flips enable polarity and bus timing
// - UTOPIA: host enables come from pipeline registers
// - UTOPIA: transmit data captured with enable edge
// - Cascade: enables active high from FIFO flags
// - Cascade: transmit data captured one cycle later
// - Receive data driven cycle after enable
// - UTOPIA: all FIFO flags active low
// - Cascade: full/empty high, cell-available stay low
// - Address straps set port address compared
// - Selected only on address match plus enable
// - Two-bit strap picks receive discard mode
// - Reset held low at least one clock
// - Test select low forces diagnostic mode
`timescale 1ns/1ps
`default_nettype none

`include "uchp_consts.svh"

module uchp_device_end
	import uchp_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	uchp_if.device_end                     bus,
	input  wire logic [`UCHP_ADDR_W-1:0]   chip_address_strap,
	input  wire logic [1:0]                cell_discard_policy,
	input  wire logic                      test_select_b,
	output logic      [`UCHP_DATA_W-1:0]   tx_out_data,
	output logic                           tx_out_valid,
	input  wire logic                      tx_out_ready,
	input  wire logic [`UCHP_DATA_W-1:0]   rx_in_data,
	input  wire logic                      rx_in_valid,
	input  wire logic                      rx_in_error,
	output logic                           rx_in_ready,
	output logic                           rx_discard,
	output logic                           test_mode,
	output logic                           cascade_mode
);
	// DEPTH must be a power of two so the pointers wrap by themselves
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam int SW = 1 + `UCHP_ADDR_W + 2;

	logic [SW-1:0]             strap_meta;
	logic [SW-1:0]             strap_sync;
	logic                      test_meta;
	logic                      test_sync;
	logic [1:0]                warm;
	logic                      cfg_loaded;
	logic [`UCHP_ADDR_W-1:0]   own_addr;
	uchp_policy_type           policy;
	logic                      port_on;
	logic                      tx_sel;
	logic                      tx_sel_d;
	logic                      tx_capture;
	logic                      rx_sel;
	logic [`UCHP_DATA_W-1:0]   tx_mem [DEPTH];
	logic [`UCHP_DATA_W-1:0]   rx_mem [DEPTH];
	logic [PW-1:0]             tx_wp;
	logic [PW-1:0]             tx_rp;
	logic [PW-1:0]             rx_wp;
	logic [PW-1:0]             rx_rp;
	logic [PW:0]               tx_count;
	logic [PW:0]               rx_count;
	logic [PW:0]               next_tx_count;
	logic [PW:0]               next_rx_count;
	logic                      tx_push;
	logic                      tx_pop;
	logic                      rx_push;
	logic                      rx_pop;
	logic                      rx_drop;
	logic                      drop_on_full;
	logic                      drop_errored;

	// Enable pin to active level under the latched mode
	function automatic logic enable_active(input logic pin, input logic casc);
		return casc ? pin : !pin;
	endfunction

	// Active state of a FIFO flag to its pin level
	function automatic logic flag_level(input logic active, input logic casc);
		return casc ? active : !active;
	endfunction

	// Port address compare; the spare code never matches
	function automatic logic addr_match(input logic [`UCHP_ADDR_W-1:0] addr,
			input logic [`UCHP_ADDR_W-1:0] mine);
		return (addr == mine) && (mine != `UCHP_NULL_PORT);
	endfunction

	// Straps and test pin are asynchronous board levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_meta <= '0;
			strap_sync <= '0;
			test_meta  <= 1'b1;
			test_sync  <= 1'b1;
		end else begin
			strap_meta <= {bus.fifo_cascade_select, chip_address_strap, cell_discard_policy};
			strap_sync <= strap_meta;
			test_meta  <= test_select_b;
			test_sync  <= test_meta;
		end
	end

	// Straps latched once after release; later changes wait for reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warm         <= 2'h0;
			cfg_loaded   <= 1'b0;
			cascade_mode <= 1'b0;
			own_addr     <= `UCHP_NULL_PORT;
			policy       <= uchp_keep_all;
		end else begin
			warm <= {warm[0], 1'b1};
			if (warm[1] && !cfg_loaded) begin
				cfg_loaded   <= 1'b1;
				cascade_mode <= strap_sync[SW-1];
				own_addr     <= strap_sync[2 +: `UCHP_ADDR_W];
				policy       <= uchp_policy_type'(strap_sync[1:0]);
			end
		end
	end

	// Diagnostic mode takes the port off the bus
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			test_mode <= 1'b0;
		end else begin
			test_mode <= !test_sync;
		end
	end

	assign port_on = cfg_loaded && !test_mode;

	// Selection per direction needs both address and enable
	assign tx_sel = port_on && enable_active(bus.transmit_bus_enable, cascade_mode)
			&& addr_match(bus.transmit_port_address, own_addr);
	assign rx_sel = port_on && enable_active(bus.receive_bus_enable, cascade_mode)
			&& addr_match(bus.receive_port_address, own_addr);

	// Cascade data trails the enable by one cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sel_d <= 1'b0;
		end else begin
			tx_sel_d <= tx_sel && cascade_mode;
		end
	end

	assign tx_capture = cascade_mode ? tx_sel_d : tx_sel;

	// Overrun is dropped silently; the full flag warned the host
	assign tx_push = tx_capture && (tx_count != FULL_COUNT);
	assign tx_pop  = (tx_count != '0) && (!tx_out_valid || tx_out_ready);
	assign rx_pop  = rx_sel && (rx_count != '0);

	// Discard decision on cells offered by the receiver
	assign drop_errored = (policy == uchp_drop_errored) || (policy == uchp_drop_both);
	assign drop_on_full = (policy == uchp_drop_on_full) || (policy == uchp_drop_both);
	assign rx_drop = (rx_in_error && drop_errored)
			|| ((rx_count == FULL_COUNT) && drop_on_full);
	assign rx_push = rx_in_valid && rx_in_ready && !rx_drop && (rx_count != FULL_COUNT);

	assign next_tx_count = tx_count + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
	assign next_rx_count = rx_count + (PW+1)'(rx_push) - (PW+1)'(rx_pop);

	// Transmit FIFO storage
	always_ff @(posedge clk) begin
		if (tx_push) begin
			tx_mem[tx_wp] <= bus.transmit_data;
		end
	end

	// Transmit FIFO pointers and output stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_wp        <= '0;
			tx_rp        <= '0;
			tx_count     <= '0;
			tx_out_valid <= 1'b0;
			tx_out_data  <= '0;
		end else begin
			tx_count <= next_tx_count;
			if (tx_push) begin
				tx_wp <= tx_wp + 1'b1;
			end
			if (tx_pop) begin
				tx_rp        <= tx_rp + 1'b1;
				tx_out_data  <= tx_mem[tx_rp];
				tx_out_valid <= 1'b1;
			end else if (tx_out_ready) begin
				tx_out_valid <= 1'b0;
			end
		end
	end

	// Receive FIFO storage
	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[rx_wp] <= rx_in_data;
		end
	end

	// Receive FIFO pointers and discard report
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_wp       <= '0;
			rx_rp       <= '0;
			rx_count    <= '0;
			rx_in_ready <= 1'b0;
			rx_discard  <= 1'b0;
		end else begin
			rx_count <= next_rx_count;
			if (rx_push) begin
				rx_wp <= rx_wp + 1'b1;
			end
			if (rx_pop) begin
				rx_rp <= rx_rp + 1'b1;
			end
			// Dropping on full means the receiver is never held off
			rx_in_ready <= cfg_loaded && (drop_on_full || (next_rx_count != FULL_COUNT));
			rx_discard  <= rx_in_valid && rx_in_ready && rx_drop;
		end
	end

	// Receive bus driven for exactly the cycle after selection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.receive_data_out <= '0;
			bus.receive_data_oe  <= 1'b0;
		end else begin
			bus.receive_data_oe <= rx_sel;
			if (rx_sel) begin
				bus.receive_data_out <= rx_mem[rx_rp];
			end
		end
	end

	// Flags built from next counts so a paced host never sees stale room
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.transmit_full             <= 1'b1;
			bus.receive_empty             <= 1'b0;
			bus.transmit_cell_available_b <= 1'b1;
			bus.receive_cell_available_b  <= 1'b1;
		end else begin
			bus.transmit_full <= flag_level(next_tx_count == FULL_COUNT, cascade_mode);
			bus.receive_empty <= flag_level(next_rx_count == '0, cascade_mode);
			bus.transmit_cell_available_b <= !port_on || (next_tx_count == FULL_COUNT);
			bus.receive_cell_available_b  <= !port_on || (next_rx_count == '0);
		end
	end
endmodule

`default_nettype wire

// File: core/uchp_host_end.sv
`timescale 1ns/1ps
`default_nettype none

`include "uchp_consts.svh"

module uchp_host_end
	import uchp_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	uchp_if.host_end                       bus,
	input  wire logic [`UCHP_REG_W-1:0]    reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	output logic                           irq
);
	logic                      casc_meta;
	logic                      casc;
	uchp_step_type             tx_step;
	uchp_step_type             rx_step;
	logic [`UCHP_ADDR_W-1:0]   target_port;
	logic [`UCHP_DATA_W-1:0]   tx_hold;
	logic                      tx_pending;
	logic [`UCHP_DATA_W-1:0]   rx_hold;
	logic                      rx_valid;
	logic                      tx_go;
	logic                      rx_go;
	logic                      tx_done;
	logic                      wr_tx;
	logic [`UCHP_IRQ_W-1:0]    int_status;
	logic [`UCHP_IRQ_W-1:0]    int_enable;
	logic [`UCHP_IRQ_W-1:0]    next_int_status;
	logic [`UCHP_IRQ_W-1:0]    events;
	logic [31:0]               status_word;

	// Mode strap is a board level
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			casc_meta <= 1'b0;
			casc      <= 1'b0;
		end else begin
			casc_meta <= bus.fifo_cascade_select;
			casc      <= casc_meta;
		end
	end

	// One transfer outstanding per direction keeps flag reads exact
	assign tx_go = (tx_step == uchp_idle) && tx_pending && !bus.transmit_cell_available_b;
	assign rx_go = (rx_step == uchp_idle) && !rx_valid && !bus.receive_cell_available_b;
	assign tx_done = (tx_step == uchp_capture) || ((tx_step == uchp_enable) && !casc);
	assign wr_tx = reg_wr && (reg_addr == `UCHP_REG_TX_DATA);

	// Enable pins are registered; inactive level follows the mode
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.transmit_bus_enable   <= 1'b1;
			bus.receive_bus_enable    <= 1'b1;
			bus.transmit_port_address <= `UCHP_NULL_PORT;
			bus.receive_port_address  <= `UCHP_NULL_PORT;
			bus.transmit_data         <= '0;
		end else begin
			bus.transmit_bus_enable <= casc ? tx_go : !tx_go;
			bus.receive_bus_enable  <= casc ? rx_go : !rx_go;
			if (tx_go) begin
				bus.transmit_port_address <= target_port;
				bus.transmit_data         <= tx_hold;
			end
			if (rx_go) begin
				bus.receive_port_address <= target_port;
			end
		end
	end

	// Transmit sequencer: cascade holds data one extra cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_step <= uchp_idle;
		end else begin
			unique case (tx_step)
				uchp_idle: begin
					if (tx_go) begin
						tx_step <= uchp_enable;
					end
				end
				uchp_enable: begin
					tx_step <= casc ? uchp_capture : uchp_idle;
				end
				uchp_capture: begin
					tx_step <= uchp_idle;
				end
				default: begin
					tx_step <= uchp_idle;
				end
			endcase
		end
	end

	// Receive sequencer: data stands the cycle after the enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_step <= uchp_idle;
		end else begin
			unique case (rx_step)
				uchp_idle: begin
					if (rx_go) begin
						rx_step <= uchp_enable;
					end
				end
				uchp_enable: begin
					rx_step <= uchp_capture;
				end
				uchp_capture: begin
					rx_step <= uchp_idle;
				end
				default: begin
					rx_step <= uchp_idle;
				end
			endcase
		end
	end

	// Holding registers behind the software port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_hold     <= '0;
			tx_pending  <= 1'b0;
			rx_hold     <= '0;
			rx_valid    <= 1'b0;
			target_port <= `UCHP_RST_PORT;
			int_enable  <= `UCHP_RST_INT_EN;
		end else begin
			if (wr_tx && !tx_pending) begin
				tx_hold    <= reg_wdata[`UCHP_DATA_W-1:0];
				tx_pending <= 1'b1;
			end else if (tx_done) begin
				tx_pending <= 1'b0;
			end
			if (rx_step == uchp_capture) begin
				rx_hold  <= bus.receive_data;
				rx_valid <= 1'b1;
			end else if (reg_rd && (reg_addr == `UCHP_REG_RX_DATA)) begin
				rx_valid <= 1'b0;
			end
			if (reg_wr && (reg_addr == `UCHP_REG_PORT)) begin
				target_port <= reg_wdata[`UCHP_ADDR_W-1:0];
			end
			if (reg_wr && (reg_addr == `UCHP_REG_INT_EN)) begin
				int_enable <= reg_wdata[`UCHP_IRQ_W-1:0];
			end
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_comb begin
		events = '0;
		events[`UCHP_IRQ_TX_DONE]  = tx_done;
		events[`UCHP_IRQ_RX_READY] = (rx_step == uchp_capture);
		events[`UCHP_IRQ_TX_DROP]  = wr_tx && tx_pending;
		next_int_status = int_status;
		if (reg_wr && (reg_addr == `UCHP_REG_INT_CLR)) begin
			next_int_status = int_status & ~reg_wdata[`UCHP_IRQ_W-1:0];
		end
		next_int_status = next_int_status | events;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_status <= '0;
			irq        <= 1'b0;
		end else begin
			int_status <= next_int_status;
			irq        <= |(next_int_status & int_enable);
		end
	end

	// Status view of the controller and the device flags
	always_comb begin
		status_word = '0;
		status_word[`UCHP_ST_TX_BUSY]   = tx_pending;
		status_word[`UCHP_ST_RX_VALID]  = rx_valid;
		status_word[`UCHP_ST_CASCADE]   = casc;
		status_word[`UCHP_ST_TX_FULL]   = bus.transmit_full;
		status_word[`UCHP_ST_RX_EMPTY]  = bus.receive_empty;
		status_word[`UCHP_ST_TX_CLAV_B] = bus.transmit_cell_available_b;
		status_word[`UCHP_ST_RX_CLAV_B] = bus.receive_cell_available_b;
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					`UCHP_REG_RX_DATA:  reg_rdata <= 32'(rx_hold);
					`UCHP_REG_STATUS:   reg_rdata <= status_word;
					`UCHP_REG_PORT:     reg_rdata <= 32'(target_port);
					`UCHP_REG_INT_STAT: reg_rdata <= 32'(int_status);
					`UCHP_REG_INT_EN:   reg_rdata <= 32'(int_enable);
					default:            reg_rdata <= '0;
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// File: core/uchp_if.sv
`timescale 1ns/1ps
`default_nettype none

`include "uchp_consts.svh"

interface uchp_if;
	logic                      fifo_cascade_select;
	logic                      transmit_bus_enable;
	logic [`UCHP_ADDR_W-1:0]   transmit_port_address;
	logic [`UCHP_DATA_W-1:0]   transmit_data;
	logic                      transmit_full;
	logic                      transmit_cell_available_b;
	logic                      receive_bus_enable;
	logic [`UCHP_ADDR_W-1:0]   receive_port_address;
	logic [`UCHP_DATA_W-1:0]   receive_data_out;
	logic                      receive_data_oe;
	wire  [`UCHP_DATA_W-1:0]   receive_data;
	logic                      receive_empty;
	logic                      receive_cell_available_b;

	// Undriven bus shows the inverse word, so a mistimed sample is caught
	assign receive_data = receive_data_oe ? receive_data_out : ~receive_data_out;

	modport device_end (
		input  fifo_cascade_select,
		input  transmit_bus_enable,
		input  transmit_port_address,
		input  transmit_data,
		output transmit_full,
		output transmit_cell_available_b,
		input  receive_bus_enable,
		input  receive_port_address,
		output receive_data_out,
		output receive_data_oe,
		output receive_empty,
		output receive_cell_available_b
	);

	modport host_end (
		input  fifo_cascade_select,
		output transmit_bus_enable,
		output transmit_port_address,
		output transmit_data,
		input  transmit_full,
		input  transmit_cell_available_b,
		output receive_bus_enable,
		output receive_port_address,
		input  receive_data,
		input  receive_empty,
		input  receive_cell_available_b
	);
endinterface

`default_nettype wire

// File: core/uchp_pkg.sv
package uchp_pkg;

	// Receive cell discard modes picked by the two-bit strap
	typedef enum logic [1:0] {
		uchp_keep_all,
		uchp_drop_errored,
		uchp_drop_on_full,
		uchp_drop_both
	} uchp_policy_type;

	// Controller transfer sequencer, one per direction
	typedef enum logic [1:0] {
		uchp_idle,
		uchp_enable,
		uchp_capture
	} uchp_step_type;

endpackage

// File: verification/tb_utopia_cascade_host_port.sv
`timescale 1ns/1ps
`default_nettype none

`include "uchp_consts.svh"

module tb_utopia_cascade_host_port;
	logic                    clk;
	logic                    rst_b;
	logic [1:0]              policy;
	logic [`UCHP_ADDR_W-1:0] addr_strap;
	logic                    test_select_b;
	logic [`UCHP_DATA_W-1:0] tx_out_data;
	logic                    tx_out_valid;
	logic                    tx_out_ready;
	logic [`UCHP_DATA_W-1:0] rx_in_data;
	logic                    rx_in_valid;
	logic                    rx_in_error;
	logic                    rx_in_ready;
	logic                    rx_discard;
	logic                    test_mode;
	logic                    cascade_mode;
	logic [`UCHP_REG_W-1:0]  reg_addr;
	logic [31:0]             reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [31:0]             reg_rdata;
	logic                    irq;
	int                      err_count;
	int                      cmp_count;
	int                      drop_count;

	uchp_if bus_if ();

	uchp_device_end uchp_device_end_i (
		.clk(clk), .rst_b(rst_b), .bus(bus_if), .chip_address_strap(addr_strap),
		.cell_discard_policy(policy), .test_select_b(test_select_b),
		.tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
		.rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid), .rx_in_error(rx_in_error),
		.rx_in_ready(rx_in_ready), .rx_discard(rx_discard), .test_mode(test_mode),
		.cascade_mode(cascade_mode)
	);

	uchp_host_end uchp_host_end_i (
		.clk(clk), .rst_b(rst_b), .bus(bus_if), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
	);

	uchp_monitor uchp_monitor_i (
		.clk(clk), .rst_b(rst_b), .chip_address_strap(addr_strap),
		.fifo_cascade_select(bus_if.fifo_cascade_select),
		.transmit_bus_enable(bus_if.transmit_bus_enable),
		.transmit_port_address(bus_if.transmit_port_address),
		.transmit_data(bus_if.transmit_data), .transmit_full(bus_if.transmit_full),
		.transmit_cell_available_b(bus_if.transmit_cell_available_b),
		.receive_bus_enable(bus_if.receive_bus_enable),
		.receive_port_address(bus_if.receive_port_address),
		.receive_data_oe(bus_if.receive_data_oe), .receive_empty(bus_if.receive_empty),
		.receive_cell_available_b(bus_if.receive_cell_available_b)
	);

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Discard pulses tallied; scenarios compare deltas
	always @(posedge clk) begin
		if (rx_discard === 1'b1) begin
			drop_count++;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (err_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Bounded wait: sel 1 waits for irq, 0 for an outgoing byte
	task automatic wait_on(input bit sel);
		for (int i = 0; i < 40 && (sel ? irq : tx_out_valid) !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic send_rx(input logic [7:0] b, input logic err);
		for (int i = 0; i < 40 && rx_in_ready !== 1'b1; i++) @(posedge clk);
		@(posedge clk);
		rx_in_data  <= b;
		rx_in_valid <= 1'b1;
		rx_in_error <= err;
		@(posedge clk);
		rx_in_valid <= 1'b0;
	endtask

	task automatic rx_expect(input logic [7:0] b);
		wait_on(1'b1);
		check(irq, 1'b1);
		reg_check(`UCHP_REG_RX_DATA, {24'h0, b});
		reg_write(`UCHP_REG_INT_CLR, 32'h7);
	endtask

	// One pass per strap setting; straps only move under reset
	task automatic run_mode(input logic c, input logic [1:0] pol, input logic [2:0] a);
		int drops;
		@(posedge clk);
		bus_if.fifo_cascade_select <= c;
		policy                     <= pol;
		addr_strap                 <= a;
		rst_b                      <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check(cascade_mode, c);
		check(bus_if.transmit_full, !c);
		check(bus_if.receive_empty, c);
		check(bus_if.transmit_cell_available_b, 1'b0);
		check(bus_if.receive_cell_available_b, 1'b1);
		check(rx_in_ready, 1'b1);
		reg_check(`UCHP_REG_PORT, 32'h0);
		reg_check(`UCHP_REG_INT_EN, 32'h0);
		reg_check(8'h1c, 32'h0);
		reg_check(`UCHP_REG_STATUS, {25'h0, 2'b10, c, !c, c, 2'b00});
		reg_write(`UCHP_REG_PORT, {29'h0, a});
		reg_write(`UCHP_REG_INT_EN, 32'h7);
		reg_write(`UCHP_REG_TX_DATA, 32'ha5);
		wait_on(1'b0);
		check(tx_out_data, 8'ha5);
		check(irq, 1'b1);
		reg_check(`UCHP_REG_INT_STAT, 32'h1);
		reg_write(`UCHP_REG_INT_CLR, 32'h7);
		@(posedge clk);
		tx_out_ready <= 1'b1;
		@(posedge clk);
		tx_out_ready <= 1'b0;
		#1;
		check(irq, 1'b0);
		drops = drop_count;
		send_rx(8'hee, 1'b1);
		if (pol[0]) begin
			repeat (20) @(posedge clk);
			check(drop_count - drops, 1);
			check(irq, 1'b0);
		end else begin
			rx_expect(8'hee);
		end
		send_rx(8'h3c, 1'b0);
		rx_expect(8'h3c);
		// Wrong port address: the byte must never be taken
		reg_write(`UCHP_REG_PORT, {29'h0, a ^ 3'h6});
		reg_write(`UCHP_REG_TX_DATA, 32'h11);
		repeat (20) @(posedge clk);
		check(tx_out_valid, 1'b0);
		test_select_b <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check(test_mode, 1'b1);
		check(bus_if.transmit_cell_available_b, 1'b1);
		@(posedge clk);
		test_select_b <= 1'b1;
	endtask

	// Main sequence: every discard policy, both modes, four strap addresses
	initial begin
		clk                        = 1'b0;
		rst_b                      = 1'b0;
		policy                     = 2'h0;
		test_select_b              = 1'b1;
		tx_out_ready               = 1'b0;
		rx_in_data                 = 8'h00;
		rx_in_valid                = 1'b0;
		rx_in_error                = 1'b0;
		reg_addr                   = 8'h00;
		reg_wdata                  = 32'h0;
		reg_wr                     = 1'b0;
		reg_rd                     = 1'b0;
		bus_if.fifo_cascade_select = 1'b0;
		addr_strap                 = 3'h3;
		run_mode(1'b0, 2'h0, 3'h3);
		run_mode(1'b1, 2'h1, 3'h5);
		run_mode(1'b0, 2'h3, 3'h6);
		run_mode(1'b1, 2'h2, 3'h1);
		give_verdict();
	end

	// Watchdog well past the roughly 380 cycles the four passes need
	initial begin
		#20000;
		err_count++;
		give_verdict();
	end
endmodule

`default_nettype wire

// File: verification/uchp_monitor.sv
`timescale 1ns/1ps
`default_nettype none

`include "uchp_consts.svh"

module uchp_monitor (
	input wire logic                    clk,
	input wire logic                    rst_b,
	input wire logic [`UCHP_ADDR_W-1:0] chip_address_strap,
	input wire logic                    fifo_cascade_select,
	input wire logic                    transmit_bus_enable,
	input wire logic [`UCHP_ADDR_W-1:0] transmit_port_address,
	input wire logic [`UCHP_DATA_W-1:0] transmit_data,
	input wire logic                    transmit_full,
	input wire logic                    transmit_cell_available_b,
	input wire logic                    receive_bus_enable,
	input wire logic [`UCHP_ADDR_W-1:0] receive_port_address,
	input wire logic                    receive_data_oe,
	input wire logic                    receive_empty,
	input wire logic                    receive_cell_available_b
);
	logic [3:0] age;
	logic       live;
	logic       tx_act;
	logic       rx_act;
	logic       casc;

	// Enables seen active in the polarity the strap picks
	assign casc   = fifo_cascade_select;
	assign tx_act = transmit_bus_enable ~^ casc;
	assign rx_act = receive_bus_enable ~^ casc;
	assign live   = age[3];

	// Straps settle a few edges after release, so checks wait
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			age <= 4'h0;
		end else if (!live) begin
			age <= age + 4'h1;
		end
	end

	default clocking mon_cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_rx_next_cycle: assert property (
		live && rx_act && receive_port_address == chip_address_strap |=> receive_data_oe)
		else $error("receive data not driven after enable");
	chk_rx_oe_cause: assert property (
		live && receive_data_oe |-> $past(rx_act)
			&& $past(receive_port_address) == chip_address_strap)
		else $error("receive bus driven without selection");
	chk_rx_oe_single: assert property (
		live && receive_data_oe |=> !receive_data_oe)
		else $error("receive bus driven too long");
	chk_tx_enable_pulse: assert property (
		live && tx_act |=> !tx_act)
		else $error("transmit enable held too long");
	chk_cascade_hold: assert property (
		live && casc && tx_act |=> $stable(transmit_data) && $stable(transmit_port_address))
		else $error("cascade transmit data not held");
	chk_utopia_tx_flag: assert property (
		live && !casc && !transmit_cell_available_b |-> transmit_full)
		else $error("full flag polarity wrong");
	chk_cascade_tx_flag: assert property (
		live && casc && !transmit_cell_available_b |-> !transmit_full)
		else $error("cascade full flag polarity wrong");
	chk_utopia_rx_flag: assert property (
		live && !casc && !receive_cell_available_b |-> receive_empty)
		else $error("empty flag polarity wrong");
	chk_cascade_rx_flag: assert property (
		live && casc && !receive_cell_available_b |-> !receive_empty)
		else $error("cascade empty flag polarity wrong");
endmodule

`default_nettype wire
